// ==== inc/csg_defines.svh ====
`ifndef CSG_DEFINES_SVH
`define CSG_DEFINES_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CSG_CLK_HZ        25000000
`define CSG_TICK_HZ       1000
`define CSG_TICK_DIV      (`CSG_CLK_HZ / `CSG_TICK_HZ)
`define CSG_HOLD_MS       250
`define CSG_HOLD_TICKS    ((`CSG_HOLD_MS * `CSG_TICK_HZ + 999) / 1000)
`define CSG_DEB_MS        10
`define CSG_DEB_TICKS     ((`CSG_DEB_MS * `CSG_TICK_HZ + 999) / 1000)
`define CSG_WDT_MS        1000
`define CSG_WDT_TICKS     ((`CSG_WDT_MS * `CSG_TICK_HZ + 999) / 1000)
`define CSG_CNT_RST       16'h0000
`endif

// ==== inc/csg_pkg.sv ====
package csg_pkg;
  typedef enum logic [1:0] {
    CSG_RUN  = 2'b00,
    CSG_HOLD = 2'b01
  } csg_state_t;

  typedef struct packed {
    logic ram_sel_in_n;
    logic upper_byte_en_n;
    logic lower_byte_en_n;
  } csg_ram_req_t;

  typedef struct packed {
    logic ram_sel_hi_out_n;
    logic ram_sel_lo_out_n;
  } csg_ram_sel_t;
endpackage : csg_pkg

// ==== hw/csg_tick.sv ====
`timescale 1ns/1ns
`include "csg_defines.svh"
module csg_tick #(
  parameter int unsigned DIV = `CSG_TICK_DIV
) (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  output logic      o_tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  if (DIV < 2) begin : g_bad_div
    $error("csg_tick: DIV must be at least 2");
  end
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         tick_d;
  logic         tick_q;

  // ---------------------------------------------------------------
  // slow timebase divider
  // ---------------------------------------------------------------
  always_comb begin
    tick_d = (cnt_q == W'(DIV - 1));
    cnt_d  = tick_d ? '0 : cnt_q + W'(1);
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign o_tick = tick_q;

  AST_TICK_ONE: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    o_tick |=> !o_tick) else $error("tick lasted more than one cycle");
endmodule : csg_tick

// ==== hw/csg_supervisor.sv ====
`timescale 1ns/1ns
`include "csg_defines.svh"
module csg_supervisor #(
  parameter int unsigned TICK_DIV   = `CSG_TICK_DIV,
  parameter int unsigned HOLD_TICKS = `CSG_HOLD_TICKS,
  parameter int unsigned DEB_TICKS  = `CSG_DEB_TICKS,
  parameter int unsigned WDT_TICKS  = `CSG_WDT_TICKS
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  input  wire logic                  i_supply_ok,
  input  wire logic                  i_strobe_n,
  input  wire logic                  i_cpu_rst_n,
  input  wire csg_pkg::csg_ram_req_t i_ram_req,
  output logic                       o_cpu_rst_n,
  output logic                       o_cpu_rst_oe,
  output logic                       o_power_fail,
  output csg_pkg::csg_ram_sel_t      o_ram_sel
);
  import csg_pkg::*;

  if (HOLD_TICKS < 1 || HOLD_TICKS > 65535) begin : g_bad_hold
    $error("bad HOLD_TICKS");
  end
  if (DEB_TICKS < 1 || DEB_TICKS > 65535) begin : g_bad_deb
    $error("bad DEB_TICKS");
  end
  if (WDT_TICKS < 1 || WDT_TICKS > 65535) begin : g_bad_wdt
    $error("bad WDT_TICKS");
  end

  logic tick;

  csg_tick #(.DIV(TICK_DIV)) u_tick (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .o_tick    (tick)
  );

  // ---------------------------------------------------------------
  // pushbutton debounce on the shared reset pin
  // ---------------------------------------------------------------
  logic [15:0] deb_q;
  logic [15:0] deb_d;
  logic        press_q;
  logic        press_d;
  logic        press_ev;
  logic        pin_low;
  csg_state_t  st_q;
  csg_state_t  st_d;

  // own drive is masked so our reset does not retrigger itself
  assign pin_low = !i_cpu_rst_n && (st_q == CSG_RUN);

  always_comb begin
    deb_d    = deb_q;
    press_d  = press_q;
    press_ev = 1'b0;
    if (!pin_low) begin
      deb_d   = `CSG_CNT_RST;
      press_d = 1'b0;
    end else if (!press_q && tick) begin
      if (deb_q == 16'(DEB_TICKS - 1)) begin
        press_d  = 1'b1;
        press_ev = 1'b1;
      end else begin
        deb_d = deb_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      deb_q   <= `CSG_CNT_RST;
      press_q <= 1'b0;
    end else begin
      deb_q   <= deb_d;
      press_q <= press_d;
    end
  end

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  logic [15:0] wdt_q;
  logic [15:0] wdt_d;
  logic        wdt_exp;

  always_comb begin
    wdt_d   = wdt_q;
    wdt_exp = 1'b0;
    if (!i_strobe_n || st_q == CSG_HOLD) begin
      wdt_d = `CSG_CNT_RST;
    end else if (tick) begin
      if (wdt_q == 16'(WDT_TICKS - 1)) begin
        wdt_exp = 1'b1;
        wdt_d   = `CSG_CNT_RST;
      end else begin
        wdt_d = wdt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wdt_q <= `CSG_CNT_RST;
    end else begin
      wdt_q <= wdt_d;
    end
  end

  // ---------------------------------------------------------------
  // reset hold sequencer
  // ---------------------------------------------------------------
  logic [15:0] hold_q;
  logic [15:0] hold_d;
  logic        pf;

  assign pf = !i_supply_ok;

  always_comb begin
    st_d   = st_q;
    hold_d = hold_q;
    unique case (st_q)
      CSG_RUN: begin
        hold_d = `CSG_CNT_RST;
        if (pf || press_ev || wdt_exp) begin
          st_d = CSG_HOLD;
        end
      end
      CSG_HOLD: begin
        if (pf) begin
          hold_d = `CSG_CNT_RST;
        end else if (tick) begin
          if (hold_q == 16'(HOLD_TICKS - 1)) begin
            st_d   = CSG_RUN;
            hold_d = `CSG_CNT_RST;
          end else begin
            hold_d = hold_q + 16'h0001;
          end
        end
      end
      default: begin
        st_d   = CSG_HOLD;
        hold_d = `CSG_CNT_RST;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q   <= CSG_HOLD;
      hold_q <= `CSG_CNT_RST;
    end else begin
      st_q   <= st_d;
      hold_q <= hold_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic         pf_q;
  csg_ram_sel_t sel_q;
  csg_ram_sel_t sel_d;

  // one byte lane: enabled only when select and byte enable are both low
  function automatic logic gate_sel(input logic sel_n, input logic byte_n);
    return sel_n | byte_n;
  endfunction : gate_sel

  always_comb begin
    sel_d.ram_sel_hi_out_n = 1'b1;
    sel_d.ram_sel_lo_out_n = 1'b1;
    if (!pf) begin
      sel_d.ram_sel_hi_out_n = gate_sel(i_ram_req.ram_sel_in_n,
                                        i_ram_req.upper_byte_en_n);
      sel_d.ram_sel_lo_out_n = gate_sel(i_ram_req.ram_sel_in_n,
                                        i_ram_req.lower_byte_en_n);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pf_q  <= 1'b1;
      sel_q <= '1;
    end else begin
      pf_q  <= pf;
      sel_q <= sel_d;
    end
  end

  assign o_power_fail = pf_q;
  assign o_ram_sel    = sel_q;
  assign o_cpu_rst_n  = 1'b0;
  assign o_cpu_rst_oe = (st_q == CSG_HOLD);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_recover;
    st_q == CSG_HOLD && !pf;
  endsequence

  AST_PF_RESET: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    pf |=> o_cpu_rst_oe) else $error("power fail without reset");
  AST_PF_FLAG: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    pf |=> o_power_fail) else $error("power fail flag missing");
  AST_HOLD_MIN: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (st_q == CSG_HOLD && hold_q != 16'(HOLD_TICKS - 1)) |=> o_cpu_rst_oe)
    else $error("reset released early");
  AST_HOLD_END: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (s_recover ##0 (tick && hold_q == 16'(HOLD_TICKS - 1)))
    |=> !o_cpu_rst_oe) else $error("reset not released after hold");
  AST_PRESS: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    press_ev |=> (o_cpu_rst_oe && hold_q == 16'h0000))
    else $error("press did not start full reset");
  AST_WDT: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    wdt_exp |=> o_cpu_rst_oe) else $error("watchdog expiry ignored");
  AST_STROBE: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !i_strobe_n |=> wdt_q == 16'h0000) else $error("strobe did not restart");
  AST_RAM_PROT: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    pf |=> (o_ram_sel == 2'h3)) else $error("sram enabled in power fail");
  AST_RAM_GATE: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (!pf && !i_ram_req.ram_sel_in_n && !i_ram_req.upper_byte_en_n)
    |=> !o_ram_sel.ram_sel_hi_out_n) else $error("high enable not passed");
  AST_RAM_GATE_LO: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (!pf && !i_ram_req.ram_sel_in_n && !i_ram_req.lower_byte_en_n)
    |=> !o_ram_sel.ram_sel_lo_out_n) else $error("low enable not passed");
  AST_RAM_IDLE: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_ram_req.ram_sel_in_n |=> (o_ram_sel == 2'h3))
    else $error("sram enabled without select");
  AST_OD: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    o_cpu_rst_oe |-> (!o_cpu_rst_n ##1 (deb_q == 16'h0000)))
    else $error("reset pin high or own drive taken as press");
endmodule : csg_supervisor

// ==== test/csg_host_model.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// host processor and reset pin model
// ----------------------------------------
module csg_host_model #(
  parameter int KICK = 16
) (
  input  wire logic i_clk,
  input  wire logic i_drv_n,
  input  wire logic i_oe,
  input  wire logic i_press,
  input  wire logic i_kick_en,
  output logic      o_pin_n,
  output logic      o_strobe_n
);
  int cnt = 0;
  initial o_strobe_n = 1'b1;
  // open-drain wire, pull-up when released
  assign o_pin_n = i_oe ? i_drv_n : !i_press;
  // strobe low one cycle every KICK clocks
  always @(posedge i_clk) begin
    #1;
    cnt = (cnt + 1) % KICK;
    o_strobe_n = !(i_kick_en && cnt == 0);
  end
endmodule : csg_host_model

// ==== test/tb.sv ====
`timescale 1ns/1ns
module tb;
  import csg_pkg::*;
  localparam int DIV = 4, HOLD = 5, DEB = 2, WDT = 8, KICK = 16;
  localparam int HMIN = (HOLD - 1) * DIV, HMAX = (HOLD + 1) * DIV;
  localparam int WMIN = (WDT - 1) * DIV - KICK, WMAX = (WDT + 1) * DIV;
  localparam int DMIN = (DEB - 1) * DIV, DMAX = (DEB + 1) * DIV;
  logic         i_clk = 0, i_sys_rst = 1, i_supply_ok = 1;
  logic         press = 0, kick = 1, pin_n, strobe_n, oe, drv_n, pf;
  logic [2:0]   exp_q;
  csg_ram_req_t req = '1;
  csg_ram_sel_t sel;
  integer       num_errors = 0, compares = 0, seed = 84527, n;
  always #20 i_clk = ~i_clk;
  csg_supervisor #(.TICK_DIV(DIV), .HOLD_TICKS(HOLD), .DEB_TICKS(DEB),
    .WDT_TICKS(WDT)) DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_supply_ok(i_supply_ok), .i_strobe_n(strobe_n),
    .i_cpu_rst_n(pin_n), .i_ram_req(req), .o_cpu_rst_n(drv_n),
    .o_cpu_rst_oe(oe), .o_power_fail(pf), .o_ram_sel(sel));
  csg_host_model #(.KICK(KICK)) host (.i_clk(i_clk), .i_drv_n(drv_n),
    .i_oe(oe), .i_press(press), .i_kick_en(kick), .o_pin_n(pin_n),
    .o_strobe_n(strobe_n));
  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic check(input logic [2:0] seen, input logic [2:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %b expected %b", $time, seen, exp);
    end
  endtask : check
  task automatic wait_oe(input logic v, input int max, output int c);
    c = 0;
    while (oe !== v && c < max) begin
      @(posedge i_clk);
      #1;
      c++;
    end
  endtask : wait_oe
  task automatic print_verdict;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // reference model of flag and memory gate
  // ----------------------------------------
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) exp_q <= 3'h7;
    else if (!i_supply_ok) exp_q <= 3'h7;
    else exp_q <= {1'b0, req.ram_sel_in_n | req.upper_byte_en_n,
                   req.ram_sel_in_n | req.lower_byte_en_n};
  end
  always @(negedge i_clk) begin
    if (!i_sys_rst) check({pf, sel}, exp_q);
    if (!i_sys_rst && oe) check(pin_n, 0);
  end
  always @(posedge i_clk) begin
    #1;
    req <= 3'($random(seed));
  end
  initial begin
    #(40 * 3000);
    num_errors++;
    print_verdict;
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge i_clk);
    #1 i_sys_rst = 0;
    check(oe, 1);
    wait_oe(0, 100, n);
    check(n >= HMIN && n <= HMAX, 1);
    $display("test power_up done");
    @(posedge i_clk);
    #1 i_supply_ok = 0;
    @(posedge i_clk);
    #1 check({oe, pf}, 3'h3);
    repeat (5) @(posedge i_clk);
    #1 i_supply_ok = 1;
    wait_oe(0, 100, n);
    check(n >= HMIN && n <= HMAX, 1);
    $display("test supply_dip done");
    wait_oe(1, 100, n);
    check(oe, 0);
    kick = 0;
    wait_oe(1, 4 * WDT * DIV, n);
    check(oe, 1);
    check(n >= WMIN && n <= WMAX, 1);
    kick = 1;
    wait_oe(0, 100, n);
    check(oe, 0);
    $display("test watchdog done");
    @(posedge i_clk);
    #1 press = 1;
    @(posedge i_clk);
    #1 press = 0;
    wait_oe(1, 4 * DEB * DIV, n);
    check(oe, 0);
    press = 1;
    wait_oe(1, 8 * DEB * DIV, n);
    check(oe, 1);
    check(n >= DMIN && n <= DMAX, 1);
    press = 0;
    wait_oe(0, 100, n);
    check(n >= HMIN && n <= HMAX, 1);
    $display("test pushbutton done");
    print_verdict;
  end
endmodule : tb
